// ===== src/sdc_pkg.sv
// package of sdram controller constants and types
package sdc_pkg;
  localparam int unsigned CLK_PERIOD_PS = 8000;
  // timing figures as printed, in ps, save active max in ns, init pause in us, refresh in ms
  localparam int unsigned T_PRECHARGE_GAP_PS = 16000;
  localparam int unsigned T_CROSS_ACT_GAP_PS = 16000;
  localparam int unsigned T_ACTIVE_MIN_PS = 48000;
  localparam int unsigned T_ACTIVE_MAX_NS = 100000;
  localparam int unsigned T_SAME_BANK_CYCLE_PS = 72000;
  localparam int unsigned T_ACT_TO_COL_PS = 30000;
  localparam int unsigned T_INIT_PAUSE_US = 200;
  localparam int unsigned T_REFRESH_MS = 64;
  localparam int unsigned REFRESH_ROWS = 4096;
  // cycle counts, least times rounded up save init pause, longest rounded down
  localparam int unsigned C_RP = (T_PRECHARGE_GAP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned C_RRD = (T_CROSS_ACT_GAP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned C_RAS = (T_ACTIVE_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned C_RAS_MAX = (T_ACTIVE_MAX_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned C_RC = (T_SAME_BANK_CYCLE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned C_RCD = (T_ACT_TO_COL_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned C_CCD = 1;
  localparam int unsigned C_WR = 1;
  localparam int unsigned C_INIT_PAUSE = (T_INIT_PAUSE_US * 1000000) / CLK_PERIOD_PS;
  localparam int unsigned C_REF_INTERVAL =
    (T_REFRESH_MS * 1000000 / REFRESH_ROWS) * 1000 / CLK_PERIOD_PS;
  localparam int unsigned INIT_REFRESHES = 2;
  localparam int unsigned NUM_BANKS = 2;
  localparam int unsigned TIMER_W = 16;
  // command encodings {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam int unsigned A10_BIT = 10;
  localparam logic [11:0] MODE_DEFAULT = 12'h020;
  // user request opcodes
  localparam logic [1:0] OP_READ = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  typedef enum logic [3:0] {
    ST_PAUSE = 4'h0, ST_PRE_ALL = 4'h1, ST_INIT_REF = 4'h2, ST_MRS = 4'h3,
    ST_IDLE = 4'h4, ST_ACT = 4'h5, ST_COL = 4'h6, ST_PRE = 4'h7,
    ST_REF = 4'h8, ST_WAIT = 4'h9
  } sdc_state_e;
endpackage

// ===== src/sdc_bank_if.sv
// per-bank timing bundle between controller and bank timers
`timescale 1ns/1ps
interface sdc_bank_if;
  logic act;
  logic pre;
  logic col;
  logic wr_done;
  logic act_ok;
  logic col_ok;
  logic pre_ok;
  logic ras_due;
  modport ctl (output act, output pre, output col, output wr_done,
    input act_ok, input col_ok, input pre_ok, input ras_due);
  modport tmr (input act, input pre, input col, input wr_done,
    output act_ok, output col_ok, output pre_ok, output ras_due);
endinterface

// ===== src/sdc_bank_timer.sv
// per-bank command spacing timers
`timescale 1ns/1ps
module sdc_bank_timer
  import sdc_pkg::*;
#(
  parameter int unsigned RAS_MAX = C_RAS_MAX
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  sdc_bank_if.tmr bk
);
  initial begin
    if (RAS_MAX <= C_RAS || RAS_MAX >= (1 << TIMER_W)) $error("bad RAS_MAX");
  end
  logic [TIMER_W-1:0] act_cnt_ff, pre_cnt_ff, open_cnt_ff, wr_cnt_ff;
  logic [TIMER_W-1:0] nxt_act_cnt, nxt_pre_cnt, nxt_open_cnt, nxt_wr_cnt;
  logic open_ff, nxt_open;
  wire logic [TIMER_W-1:0] c_rp = TIMER_W'(C_RP);
  wire logic [TIMER_W-1:0] c_rc = TIMER_W'(C_RC);
  wire logic [TIMER_W-1:0] c_rcd = TIMER_W'(C_RCD);
  wire logic [TIMER_W-1:0] c_ras = TIMER_W'(C_RAS);
  wire logic [TIMER_W-1:0] c_wr = TIMER_W'(C_WR);
  wire logic [TIMER_W-1:0] c_max = TIMER_W'(RAS_MAX - 8);
  // RULE_01 precharge recovery gap
  // RULE_14 same bank cycle
  assign bk.act_ok = !open_ff && pre_cnt_ff >= c_rp && act_cnt_ff >= c_rc;
  // RULE_14 activate to column
  assign bk.col_ok = open_ff && act_cnt_ff >= c_rcd;
  // RULE_03 minimum active window
  // RULE_15 write recovery
  assign bk.pre_ok = open_ff && act_cnt_ff >= c_ras && wr_cnt_ff >= c_wr;
  // RULE_03 maximum open time
  assign bk.ras_due = open_ff && open_cnt_ff >= c_max;
  wire logic [TIMER_W-1:0] sat = {TIMER_W{1'b1}};
  assign nxt_act_cnt = bk.act ? '0 : (act_cnt_ff == sat ? sat : act_cnt_ff + 1'b1);
  assign nxt_pre_cnt = bk.pre ? '0 : (pre_cnt_ff == sat ? sat : pre_cnt_ff + 1'b1);
  assign nxt_open_cnt = bk.act ? '0 : (open_cnt_ff == sat ? sat : open_cnt_ff + 1'b1);
  assign nxt_wr_cnt = bk.wr_done ? '0 : (wr_cnt_ff == sat ? sat : wr_cnt_ff + 1'b1);
  assign nxt_open = bk.act ? 1'b1 : (bk.pre ? 1'b0 : open_ff);
  always_ff @(posedge clk) begin
    if (!nrst) begin
      act_cnt_ff <= {TIMER_W{1'b1}};
      pre_cnt_ff <= {TIMER_W{1'b1}};
      open_cnt_ff <= '0;
      wr_cnt_ff <= {TIMER_W{1'b1}};
      open_ff <= 1'b0;
    end else if (ce) begin
      act_cnt_ff <= nxt_act_cnt;
      pre_cnt_ff <= nxt_pre_cnt;
      open_cnt_ff <= nxt_open_cnt;
      wr_cnt_ff <= nxt_wr_cnt;
      open_ff <= nxt_open;
    end
  end
endmodule

// ===== src/sdc_ctrl.sv
// sdram host controller: init sequence, refresh and command spacing
// Overview of operation
// RULE_01 - wait precharge gap before activate or refresh of the same bank
// RULE_02 - space activates to different banks by the cross-bank gap
// RULE_03 - keep row open at least minimum, precharge before maximum open time
// RULE_04 - column commands spaced at least one cycle apart
// RULE_05 - all nanosecond gaps become cycles, fractions rounded up
// RULE_06 - during power-up drive nop, clock enable high, both byte masks high
// RULE_07 - wait 200 microseconds before any init command
// RULE_08 - byte masks held high through the initial pause
// RULE_09 - precharge both banks after the pause, before mode load
// RULE_10 - load the mode register before normal accesses
// RULE_11 - issue at least two auto-refresh cycles during init
// RULE_12 - never leave device unrefreshed beyond the 64 ms period
// RULE_13 - lower mask covers data 0 to 7, upper mask 8 to 15
// RULE_14 - enforce same-bank cycle and activate-to-column delay
// RULE_15 - one clock write recovery before precharge
`timescale 1ns/1ps
module sdc_ctrl
  import sdc_pkg::*;
#(
  parameter int unsigned INIT_PAUSE = C_INIT_PAUSE,
  parameter int unsigned REF_INTERVAL = C_REF_INTERVAL,
  parameter int unsigned RAS_MAX = C_RAS_MAX,
  parameter logic [11:0] MODE_WORD = MODE_DEFAULT
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic CE,
  input wire logic REQ_VALID,
  input wire logic [1:0] REQ_OP,
  input wire logic REQ_BANK,
  input wire logic [10:0] REQ_ROW,
  input wire logic [7:0] REQ_COL,
  input wire logic [15:0] REQ_WDATA,
  input wire logic [1:0] REQ_BYTE_EN,
  output logic REQ_READY,
  output logic INIT_DONE,
  output logic SD_CKE,
  output logic SD_CS_N,
  output logic SD_RAS_N,
  output logic SD_CAS_N,
  output logic SD_WE_N,
  output logic SD_BANK,
  output logic [11:0] SD_ADDR,
  output logic SD_LOWER_BYTE_MASK,
  output logic SD_UPPER_BYTE_MASK,
  output logic [15:0] SD_DQ_OUT,
  output logic SD_DQ_OE
);
  initial begin
    if (INIT_PAUSE < 1 || INIT_PAUSE >= (1 << 24)) $error("bad INIT_PAUSE");
    if (REF_INTERVAL < 16 || REF_INTERVAL >= (1 << TIMER_W)) $error("bad REF_INTERVAL");
  end
  sdc_state_e state_ff, nxt_state;
  logic [23:0] wait_ff, nxt_wait;
  logic [TIMER_W-1:0] ref_cnt_ff;
  logic [TIMER_W-1:0] rrd_cnt_ff;
  logic [1:0] init_ref_ff;
  logic ref_pend_ff;
  logic [3:0] cmd_ff, nxt_cmd;
  logic bank_ff, nxt_bank;
  logic [11:0] addr_ff, nxt_addr;
  logic [1:0] mask_ff, nxt_mask;
  logic [15:0] dq_ff;
  logic oe_ff, ready_ff, done_ff;
  logic req_bank_ff, req_wr_ff;
  logic [10:0] req_row_ff;
  logic [7:0] req_col_ff;
  logic [15:0] req_wdata_ff;
  logic [1:0] req_be_ff;
  sdc_bank_if bif [NUM_BANKS] ();
  logic [NUM_BANKS-1:0] act_ok, col_ok, pre_ok, ras_due;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_BANKS; gi++) begin : g_bank
      sdc_bank_timer #(.RAS_MAX(RAS_MAX)) u_tmr (.clk(CLK), .nrst(NRST), .ce(CE),
        .bk(bif[gi]));
      assign bif[gi].act = CE && nxt_cmd == CMD_ACT && nxt_bank == gi;
      // RULE_09 precharge all hits both
      assign bif[gi].pre = CE && nxt_cmd == CMD_PRE &&
        (nxt_addr[A10_BIT] || nxt_bank == gi);
      assign bif[gi].col = CE && (nxt_cmd == CMD_READ || nxt_cmd == CMD_WRITE) &&
        nxt_bank == gi;
      assign bif[gi].wr_done = CE && nxt_cmd == CMD_WRITE && nxt_bank == gi;
      assign act_ok[gi] = bif[gi].act_ok;
      assign col_ok[gi] = bif[gi].col_ok;
      assign pre_ok[gi] = bif[gi].pre_ok;
      assign ras_due[gi] = bif[gi].ras_due;
    end
  endgenerate
  // RULE_05 rounded cycle counts from package
  wire logic rrd_ok = rrd_cnt_ff >= TIMER_W'(C_RRD);
  wire logic all_idle = &act_ok;
  wire logic ref_due = ref_cnt_ff >= TIMER_W'(REF_INTERVAL);
  wire logic pause_done = wait_ff == '0;
  wire logic take = ready_ff && REQ_VALID;
  wire logic any_ras_due = |ras_due;
  wire logic [11:0] all_banks_addr = 12'h001 << A10_BIT;
  always_comb begin
    nxt_state = state_ff;
    nxt_wait = wait_ff == '0 ? '0 : wait_ff - 1'b1;
    // RULE_06 nop default
    nxt_cmd = CMD_NOP;
    nxt_bank = bank_ff;
    nxt_addr = addr_ff;
    nxt_mask = mask_ff;
    unique case (state_ff)
      // RULE_07 power-up pause
      // RULE_08 masks high in pause
      ST_PAUSE: begin
        nxt_mask = 2'h3;
        if (pause_done) nxt_state = ST_PRE_ALL;
      end
      // RULE_09 precharge all banks
      ST_PRE_ALL: begin
        nxt_cmd = CMD_PRE;
        nxt_addr = all_banks_addr;
        nxt_state = ST_INIT_REF;
      end
      // RULE_11 two dummy refreshes
      ST_INIT_REF: begin
        if (init_ref_ff == 2'(INIT_REFRESHES)) begin
          nxt_state = ST_MRS;
        end else if (all_idle) begin
          nxt_cmd = CMD_REF;
        end
      end
      // RULE_10 mode register load
      ST_MRS: begin
        if (all_idle) begin
          nxt_cmd = CMD_MRS;
          nxt_addr = MODE_WORD;
          nxt_state = ST_WAIT;
        end
      end
      ST_WAIT: nxt_state = ST_IDLE;
      ST_IDLE: begin
        if (take) nxt_state = ST_ACT;
        else if (ref_pend_ff) nxt_state = ST_PRE;
      end
      // RULE_02 cross bank activate gap
      ST_ACT: begin
        if (act_ok[req_bank_ff] && rrd_ok) begin
          nxt_cmd = CMD_ACT;
          nxt_bank = req_bank_ff;
          nxt_addr = {1'b0, req_row_ff};
          nxt_state = ST_COL;
        end
      end
      // RULE_04 one column command per cycle
      // RULE_13 byte mask per lane
      ST_COL: begin
        if (col_ok[req_bank_ff]) begin
          nxt_cmd = req_wr_ff ? CMD_WRITE : CMD_READ;
          nxt_bank = req_bank_ff;
          nxt_addr = {4'h0, req_col_ff};
          nxt_mask = ~req_be_ff;
          nxt_state = ST_PRE;
        end
      end
      // RULE_03 close row in window
      ST_PRE: begin
        nxt_mask = 2'h0;
        if (!(|(~act_ok)) ) begin
          nxt_state = ref_pend_ff ? ST_REF : ST_IDLE;
        end else if (&(pre_ok | act_ok)) begin
          nxt_cmd = CMD_PRE;
          nxt_addr = all_banks_addr;
        end
      end
      // RULE_12 periodic refresh
      ST_REF: begin
        if (all_idle) begin
          nxt_cmd = CMD_REF;
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_PAUSE;
    endcase
    if (any_ras_due && state_ff == ST_COL) nxt_state = ST_PRE;
  end
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      state_ff <= ST_PAUSE;
      wait_ff <= 24'(INIT_PAUSE);
      cmd_ff <= CMD_NOP;
      bank_ff <= 1'b0;
      addr_ff <= '0;
      mask_ff <= 2'h3;
    end else if (CE) begin
      state_ff <= nxt_state;
      wait_ff <= nxt_wait;
      cmd_ff <= nxt_cmd;
      bank_ff <= nxt_bank;
      addr_ff <= nxt_addr;
      mask_ff <= nxt_mask;
    end
  end
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      ref_cnt_ff <= '0;
      ref_pend_ff <= 1'b0;
      rrd_cnt_ff <= {TIMER_W{1'b1}};
      init_ref_ff <= '0;
    end else if (CE) begin
      ref_cnt_ff <= (nxt_cmd == CMD_REF) ? '0 : (ref_due ? ref_cnt_ff : ref_cnt_ff + 1'b1);
      ref_pend_ff <= (ref_due && done_ff) || (ref_pend_ff && nxt_cmd != CMD_REF);
      rrd_cnt_ff <= (nxt_cmd == CMD_ACT) ? '0 :
        (rrd_cnt_ff == {TIMER_W{1'b1}} ? rrd_cnt_ff : rrd_cnt_ff + 1'b1);
      if (nxt_cmd == CMD_REF && state_ff == ST_INIT_REF) init_ref_ff <= init_ref_ff + 1'b1;
    end
  end
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      req_bank_ff <= 1'b0;
      req_wr_ff <= 1'b0;
      req_row_ff <= '0;
      req_col_ff <= '0;
      req_wdata_ff <= '0;
      req_be_ff <= '0;
      ready_ff <= 1'b0;
      done_ff <= 1'b0;
      dq_ff <= '0;
      oe_ff <= 1'b0;
    end else if (CE) begin
      if (take) begin
        req_bank_ff <= REQ_BANK;
        req_wr_ff <= REQ_OP == OP_WRITE;
        req_row_ff <= REQ_ROW;
        req_col_ff <= REQ_COL;
        req_wdata_ff <= REQ_WDATA;
        req_be_ff <= REQ_BYTE_EN;
      end
      ready_ff <= nxt_state == ST_IDLE && !ref_pend_ff && !take && state_ff == ST_IDLE;
      done_ff <= done_ff || state_ff == ST_WAIT;
      dq_ff <= req_wdata_ff;
      oe_ff <= nxt_cmd == CMD_WRITE;
    end
  end
  assign REQ_READY = ready_ff;
  assign INIT_DONE = done_ff;
  // RULE_06 clock enable held high
  assign SD_CKE = 1'b1;
  assign {SD_CS_N, SD_RAS_N, SD_CAS_N, SD_WE_N} = cmd_ff;
  assign SD_BANK = bank_ff;
  assign SD_ADDR = addr_ff;
  assign SD_LOWER_BYTE_MASK = mask_ff[0];
  assign SD_UPPER_BYTE_MASK = mask_ff[1];
  assign SD_DQ_OUT = dq_ff;
  assign SD_DQ_OE = oe_ff;
endmodule

// ===== tb/sdc_ctrl_props.sv
// assertion checker for the sdram host controller pins
`timescale 1ns/1ps
module sdc_ctrl_props
  import sdc_pkg::*;
#(
  parameter int unsigned INIT_PAUSE = C_INIT_PAUSE,
  parameter int unsigned RAS_MAX = C_RAS_MAX,
  parameter int unsigned REF_INTERVAL = C_REF_INTERVAL
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic CE,
  input wire logic INIT_DONE,
  input wire logic SD_CKE,
  input wire logic SD_CS_N,
  input wire logic SD_RAS_N,
  input wire logic SD_CAS_N,
  input wire logic SD_WE_N,
  input wire logic [11:0] SD_ADDR,
  input wire logic SD_LOWER_BYTE_MASK,
  input wire logic SD_UPPER_BYTE_MASK,
  input wire logic SD_DQ_OE
);
  wire logic [3:0] cmd = {SD_CS_N, SD_RAS_N, SD_CAS_N, SD_WE_N};
  wire logic act = cmd == CMD_ACT;
  wire logic pre = cmd == CMD_PRE;
  wire logic col = cmd == CMD_READ || cmd == CMD_WRITE;
  logic seen_ff;
  logic [15:0] wait_ff;
  logic [2:0] refs_ff;
  logic [15:0] open_ff;
  logic [15:0] ref_gap_ff;
  localparam int unsigned REF_LIMIT = REF_INTERVAL + 64;
  always_ff @(posedge CLK) begin
    if (!NRST) begin
      seen_ff <= 1'b0;
      wait_ff <= 16'h0000;
      refs_ff <= 3'h0;
      open_ff <= 16'h0000;
      ref_gap_ff <= 16'h0000;
    end else if (CE) begin
      ref_gap_ff <= (cmd == CMD_REF) ? 16'h0000 : ref_gap_ff + 16'h0001;
      seen_ff <= seen_ff || cmd != CMD_NOP;
      wait_ff <= wait_ff + {15'h0000, !seen_ff};
      refs_ff <= refs_ff + {2'h0, cmd == CMD_REF && refs_ff != 3'h7};
      open_ff <= act ? 16'h0001 : pre ? 16'h0000 : open_ff + {15'h0000, open_ff != 16'h0000};
    end
  end
  default clocking cb @(posedge CLK iff CE); endclocking
  default disable iff (!NRST);
  a_init_pins_idle: assert property (!INIT_DONE |-> SD_LOWER_BYTE_MASK && SD_UPPER_BYTE_MASK)
    else $error("masks low during init");
  a_cke_held_high: assert property (SD_CKE)
    else $error("clock enable dropped");
  a_first_cmd_pre: assert property (!seen_ff && cmd != CMD_NOP |-> pre && SD_ADDR[A10_BIT] && wait_ff >= INIT_PAUSE - 1)
    else $error("first command wrong or early");
  a_mrs_after_refs: assert property (cmd == CMD_MRS |-> refs_ff >= 3'h2)
    else $error("mode load before two refreshes");
  a_col_after_init: assert property (col |-> INIT_DONE)
    else $error("column command before init done");
  a_pre_to_act: assert property (pre |=> !(act || cmd == CMD_REF))
    else $error("activate or refresh too soon after precharge");
  a_act_spacing: assert property (act |=> !act [*8])
    else $error("activates too close");
  a_act_to_col: assert property (act |=> !col [*3])
    else $error("column command too soon after activate");
  a_row_open_min: assert property (act |=> !pre [*5])
    else $error("row closed too early");
  a_row_open_max: assert property (open_ff < RAS_MAX)
    else $error("row open too long");
  a_col_gap_one: assert property (col |=> !col)
    else $error("column commands back to back");
  a_write_recovery: assert property (cmd == CMD_WRITE |=> !pre)
    else $error("precharge without write recovery");
  a_refresh_in_time: assert property (INIT_DONE |-> ref_gap_ff < REF_LIMIT)
    else $error("refresh overdue");
  c_init_done: cover property (INIT_DONE && cmd == CMD_WRITE);
  c_read: cover property (cmd == CMD_READ);
  c_run_refresh: cover property (INIT_DONE && cmd == CMD_REF);
endmodule
bind sdc_ctrl sdc_ctrl_props #(.INIT_PAUSE(INIT_PAUSE), .RAS_MAX(RAS_MAX),
  .REF_INTERVAL(REF_INTERVAL)) u_props (
  .CLK(CLK), .NRST(NRST), .CE(CE), .INIT_DONE(INIT_DONE), .SD_CKE(SD_CKE), .SD_CS_N(SD_CS_N),
  .SD_RAS_N(SD_RAS_N), .SD_CAS_N(SD_CAS_N), .SD_WE_N(SD_WE_N), .SD_ADDR(SD_ADDR),
  .SD_LOWER_BYTE_MASK(SD_LOWER_BYTE_MASK), .SD_UPPER_BYTE_MASK(SD_UPPER_BYTE_MASK),
  .SD_DQ_OE(SD_DQ_OE));

// ===== tb/sdc_dev_model.sv
// behavioural sdram device model with timing and init checks
`timescale 1ns/1ps
module sdc_dev_model
  import sdc_pkg::*;
#(
  parameter int INIT_PAUSE = 20,
  parameter int RAS_MAX = 100
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [3:0] cmd,
  input wire logic bank,
  input wire logic [11:0] addr,
  input wire logic [1:0] mask,
  input wire logic [15:0] dq,
  input wire logic dq_oe,
  output logic acc = 1'b0,
  output logic [36:0] acc_word = '0,
  output logic [7:0] viol = 8'h00
);
  logic [15:0] mem [logic [19:0]];
  logic [10:0] row [2];
  int cyc = 0, t_rst = 0, t_pre = -99, t_any = -99, t_col = -99, t_wr = -99, refs = 0;
  int t_act [2] = '{-99, -99};
  bit init_pre, mode_set, open_row;
  logic [19:0] k;
  logic [15:0] w;
  always @(posedge clk) begin
    if (ce) cyc = cyc + 1;
    acc <= 1'b0;
    k = {bank, row[bank], addr[7:0]};
    if (!nrst) begin
      t_rst = cyc;
      refs = 0;
      init_pre = 0;
      mode_set = 0;
    end else if (ce && cmd != CMD_NOP) begin
      if (cyc - t_rst < INIT_PAUSE - 1) viol++;
      case (cmd)
        CMD_PRE: begin
          if (open_row && (cyc - t_any < C_RAS || cyc - t_any > RAS_MAX || cyc - t_wr <= C_WR)) viol++;
          t_pre = cyc;
          init_pre = init_pre || addr[10];
          open_row = 0;
        end
        CMD_REF: begin
          if (cyc - t_pre < C_RP) viol++;
          refs++;
        end
        CMD_MRS: begin
          if (!init_pre) viol++;
          mode_set = 1;
        end
        CMD_ACT: begin
          if (cyc - t_pre < C_RP || cyc - t_any < C_RRD || cyc - t_act[bank] < C_RC) viol++;
          if (!mode_set || refs < INIT_REFRESHES) viol++;
          t_act[bank] = cyc;
          t_any = cyc;
          row[bank] = addr[10:0];
          open_row = 1;
        end
        CMD_WRITE, CMD_READ: begin
          if (cyc - t_col < C_CCD || cyc - t_act[bank] < C_RCD || !open_row) viol++;
          t_col = cyc;
          if (!mem.exists(k)) mem[k] = 16'h0000;
          w = mem[k];
          if (cmd == CMD_WRITE) begin
            if (!dq_oe) viol++;
            // lower mask byte 0, upper byte 1
            if (!mask[0]) w[7:0] = dq[7:0];
            if (!mask[1]) w[15:8] = dq[15:8];
            mem[k] = w;
            t_wr = cyc;
          end
          acc <= 1'b1;
          acc_word <= {cmd == CMD_READ, k, w};
        end
        default: viol++;
      endcase
    end
  end
endmodule

// ===== tb/sdc_ctrl_tb.sv
// self-checking bench for the sdram host controller
`timescale 1ns/1ps
module sdc_ctrl_tb
  import sdc_pkg::*;
;
  logic CLK = 1'b0, NRST = 1'b0, CE = 1'b1, REQ_VALID = 1'b0, REQ_BANK = 1'b0;
  logic [1:0] REQ_OP = 2'h0, REQ_BYTE_EN = 2'h0;
  logic [10:0] REQ_ROW = 11'h000;
  logic [7:0] REQ_COL = 8'h00;
  logic [15:0] REQ_WDATA = 16'h0000;
  wire logic REQ_READY, INIT_DONE, SD_CKE, SD_CS_N, SD_RAS_N, SD_CAS_N, SD_WE_N, SD_BANK;
  wire logic SD_LOWER_BYTE_MASK, SD_UPPER_BYTE_MASK, SD_DQ_OE, acc;
  wire logic [11:0] SD_ADDR;
  wire logic [15:0] SD_DQ_OUT;
  wire logic [36:0] acc_word;
  wire logic [7:0] viol;
  int fails = 0, check_count = 0;
  logic [36:0] exp_q [$];
  logic [15:0] shadow [logic [19:0]];
  always #4 CLK = ~CLK;
  // random clock-enable gaps once out of reset
  always @(posedge CLK) CE <= !NRST || ($urandom_range(7) != 0);
  sdc_ctrl #(.INIT_PAUSE(20), .REF_INTERVAL(200), .RAS_MAX(C_RAS + 20), .MODE_WORD(MODE_DEFAULT)) dut (
    .CLK(CLK), .NRST(NRST), .CE(CE), .REQ_VALID(REQ_VALID), .REQ_OP(REQ_OP),
    .REQ_BANK(REQ_BANK), .REQ_ROW(REQ_ROW), .REQ_COL(REQ_COL), .REQ_WDATA(REQ_WDATA),
    .REQ_BYTE_EN(REQ_BYTE_EN), .REQ_READY(REQ_READY), .INIT_DONE(INIT_DONE), .SD_CKE(SD_CKE),
    .SD_CS_N(SD_CS_N), .SD_RAS_N(SD_RAS_N), .SD_CAS_N(SD_CAS_N), .SD_WE_N(SD_WE_N),
    .SD_BANK(SD_BANK), .SD_ADDR(SD_ADDR), .SD_LOWER_BYTE_MASK(SD_LOWER_BYTE_MASK),
    .SD_UPPER_BYTE_MASK(SD_UPPER_BYTE_MASK), .SD_DQ_OUT(SD_DQ_OUT), .SD_DQ_OE(SD_DQ_OE));
  sdc_dev_model #(.INIT_PAUSE(20), .RAS_MAX(C_RAS + 20)) dev (.clk(CLK), .nrst(NRST), .ce(CE),
    .cmd({SD_CS_N, SD_RAS_N, SD_CAS_N, SD_WE_N}), .bank(SD_BANK), .addr(SD_ADDR),
    .mask({SD_UPPER_BYTE_MASK, SD_LOWER_BYTE_MASK}), .dq(SD_DQ_OUT), .dq_oe(SD_DQ_OE),
    .acc(acc), .acc_word(acc_word), .viol(viol));
  task automatic check(input logic [36:0] seen, input logic [36:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic req(input logic op, input logic [19:0] k, input logic [15:0] d,
    input logic [1:0] be);
    int n;
    logic [15:0] w;
    n = 0;
    REQ_VALID <= 1'b1;
    REQ_OP <= {1'b0, op};
    {REQ_BANK, REQ_ROW, REQ_COL} <= k;
    REQ_WDATA <= d;
    REQ_BYTE_EN <= be;
    @(posedge CLK);
    while ((REQ_READY !== 1'b1 || CE !== 1'b1) && n < 400) begin
      @(posedge CLK);
      n++;
    end
    if (n >= 400) begin
      fails++;
      test_done();
    end
    if (!shadow.exists(k)) shadow[k] = 16'h0000;
    w = shadow[k];
    if (op && be[0]) w[7:0] = d[7:0];
    if (op && be[1]) w[15:8] = d[15:8];
    shadow[k] = w;
    exp_q.push_back({!op, k, w});
  endtask
  always @(posedge CLK) begin
    if (acc === 1'b1) begin
      if (exp_q.size() > 0) begin
        check(acc_word, exp_q.pop_front());
      end else begin
        fails++;
      end
    end
  end
  initial begin
    logic [19:0] k;
    void'($urandom(64));
    repeat (3) @(posedge CLK);
    NRST <= 1'b1;
    for (int r = 0; r < 2; r++) begin
      // back-to-back write and read back, every byte enable
      for (int i = 0; i < 16; i++) begin
        k = 20'($urandom);
        req(1'b1, k, 16'($urandom), 2'(i));
        req(1'b0, k, 16'($urandom), 2'h3);
      end
      REQ_VALID <= 1'b0;
      repeat (30) @(posedge CLK);
      check(37'(exp_q.size()), 37'h0);
      // reset in mid-run restarts init
      NRST <= 1'b0;
      repeat (3) @(posedge CLK);
      check(37'(INIT_DONE), 37'h0);
      check(37'(REQ_READY), 37'h0);
      NRST <= 1'b1;
    end
    check(37'(viol), 37'h0);
    test_done();
  end
  initial begin
    #100000;
    fails++;
    test_done();
  end
endmodule
